// File: lpmc_pkg.sv
package lpmc_pkg;
    // ===========================================================
    // operating modes
    typedef enum logic [2:0] {
        LPMC_RUN,
        LPMC_SLEEP,
        LPMC_LP_RUN,
        LPMC_LP_SLEEP,
        LPMC_STOP0,
        LPMC_STOP1,
        LPMC_STANDBY,
        LPMC_SHUTDOWN
    } lpmc_mode_t;

    // ===========================================================
    // software mode selection codes
    localparam logic [2:0] LPMC_SEL_STOP0 = 3'h0;
    localparam logic [2:0] LPMC_SEL_STOP1 = 3'h1;
    localparam logic [2:0] LPMC_SEL_STANDBY = 3'h3;
    localparam logic [2:0] LPMC_SEL_SHUTDOWN = 3'h4;

    // ===========================================================
    // wakeup source bit positions
    localparam int LPMC_WK_RADIO = 0;
    localparam int LPMC_WK_BROWNOUT = 1;
    localparam int LPMC_WK_VDET = 2;
    localparam int LPMC_WK_CAL = 3;
    localparam int LPMC_WK_WDOG = 4;
    localparam int LPMC_WK_SERIAL = 5;
    localparam int LPMC_WK_TWI = 6;
    localparam int LPMC_WK_TIMER_A = 7;
    localparam int LPMC_WK_TIMER_B = 8;
    localparam int LPMC_WK_COUNT = 9;

    // ===========================================================
    // pull codes and reset values
    localparam logic [1:0] LPMC_PULL_FLOAT = 2'h0;
    localparam logic [1:0] LPMC_PULL_UP = 2'h1;
    localparam logic [1:0] LPMC_PULL_DOWN = 2'h2;
    localparam logic LPMC_ANALOG_RESET = 1'h1;
    localparam logic LPMC_SRAM_GATE_RESET = 1'h1;

    // ===========================================================
    // timing: entry settling time in ns and derived cycles at 125 MHz
    localparam int LPMC_CLK_PERIOD_NS = 8;
    localparam int LPMC_ENTRY_NS = 64;
    localparam int LPMC_ENTRY_CYCLES = (LPMC_ENTRY_NS + LPMC_CLK_PERIOD_NS - 1) / LPMC_CLK_PERIOD_NS;
endpackage

// File: lpmc_osc_req.sv
`timescale 1ns/100ps
`default_nettype none
module lpmc_osc_req
    import lpmc_pkg::*;
#(
    parameter int N = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic stop_mode,
    input wire logic [N-1:0] req_async,
    output logic osc_on,
    output logic [N-1:0] route
);
    logic [N-1:0] sync1_reg;
    logic [N-1:0] sync2_reg;
    logic osc_on_reg;
    logic [N-1:0] route_reg;
    wire any_req = |sync2_reg;

    always_ff @(posedge clk) begin
        sync1_reg <= req_async;
        sync2_reg <= sync1_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            osc_on_reg <= 1'b0;
            route_reg <= '0;
        end else begin
            osc_on_reg <= stop_mode && any_req;           // [R3] [R5]
            route_reg <= stop_mode ? sync2_reg : '0;      // [R4]
        end
    end

    assign osc_on = osc_on_reg;
    assign route = route_reg;

    chk_osc_follows_req: assert property (@(posedge clk) disable iff (rst)
        (stop_mode && any_req) |=> osc_on) else $error("oscillator not started on request"); // [R3]
    chk_osc_self_off: assert property (@(posedge clk) disable iff (rst)
        !any_req |=> !osc_on) else $error("oscillator left on without request"); // [R5]
    chk_route_only_req: assert property (@(posedge clk) disable iff (rst)
        ((route & ~$past(sync2_reg)) == '0)) else $error("oscillator routed to non-requester"); // [R4]
endmodule
`default_nettype wire

// File: lpmc_top.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [R1] optional functions start disabled and run only when software enables them
// [R2] two sram banks have independent clock gates
// [R3] in stop a peripheral request starts the fast internal oscillator
// [R4] that oscillator is routed only to the requesting peripheral
// [R5] oscillator turns off when no request remains
// [R6] serial receiver wakes on start bit, address match or frame
// [R7] two-wire port wakes only on own address match
// [R8] in stop only the listed peripherals keep clock, rest frozen
// [R9] stop wakeup from reset pin, any io, and listed peripherals
// [R10] low-power run/sleep: radio, random generator and pll unavailable
// [R11] low-power timers optional down to stop, off in standby and shutdown
// [R12] watchdog runs down to standby, off only in shutdown
// [R13] standby holds io pulls as software selected
// [R14] shutdown pull selection is discarded on exit
// [R15] wake pins and calendar wake from standby or shutdown; standby also wakes from reset pin, brownout and watchdog
// [R16] fast external oscillator enabled whenever radio needs activity
// [R17] flash may power down when radio unused and code in sram
// [R18] ios analog with schmitt disabled during and after reset
// [R19] reset pin pull-up off while reset comes from inside
// [R20] low-power entry only on cpu request, target from selection field
// [R21] wakeup during entry aborts it, nothing is lost
module lpmc_top
    import lpmc_pkg::*;
#(
    parameter int NIO = 8,
    parameter int NREQ = 4
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CPU_SLEEP_REQ,
    input wire logic CPU_DEEP,
    input wire logic LP_REGULATOR,
    input wire logic [2:0] MODE_SEL,
    input wire logic [LPMC_WK_COUNT-1:0] OPT_ENABLE,
    input wire logic SRAM_A_EN,
    input wire logic SRAM_B_EN,
    input wire logic FLASH_PD_REQ,
    input wire logic CODE_IN_SRAM,
    input wire logic RADIO_ACTIVE,
    input wire logic [NREQ-1:0] OSC_REQ,
    input wire logic SERIAL_START,
    input wire logic SERIAL_ADDR_MATCH,
    input wire logic SERIAL_FRAME,
    input wire logic TWI_ADDR_MATCH,
    input wire logic [LPMC_WK_COUNT-1:0] PERIPH_WAKE,
    input wire logic [NIO-1:0] IO_WAKE,
    input wire logic WAKE_PIN_A,
    input wire logic WAKE_PIN_B,
    input wire logic RESET_PIN_WAKE,
    input wire logic INTERNAL_RESET,
    input wire logic [2*NIO-1:0] IO_PULL_SEL,
    input wire logic IO_CONFIGURED,
    output logic [2:0] MODE,
    output logic CPU_CLK_EN,
    output logic [LPMC_WK_COUNT-1:0] PERIPH_CLK_EN,
    output logic OTHER_PERIPH_CLK_EN,
    output logic SRAM_A_CLK_EN,
    output logic SRAM_B_CLK_EN,
    output logic FLASH_PD,
    output logic PLL_ALLOWED,
    output logic RNG_EN,
    output logic FAST_INT_OSC_ON,
    output logic [NREQ-1:0] FAST_INT_OSC_ROUTE,
    output logic FAST_EXT_OSC_ON,
    output logic SERIAL_WAKE_IRQ,
    output logic TWI_WAKE_IRQ,
    output logic WAKEUP,
    output logic [2*NIO-1:0] IO_PULL,
    output logic IO_ANALOG,
    output logic RESET_PULLUP_EN
);
    localparam int WK_N = LPMC_WK_COUNT;

    // ===========================================================
    // input synchronisers (pins and foreign events)
    localparam int SW = 6 + NIO + NREQ - NREQ;
    logic [SW-1:0] s1_reg;
    logic [SW-1:0] s2_reg;
    logic [WK_N-1:0] pw1_reg;
    logic [WK_N-1:0] pw2_reg;
    always_ff @(posedge CLOCK) begin
        s1_reg <= {SERIAL_START, SERIAL_ADDR_MATCH, SERIAL_FRAME, TWI_ADDR_MATCH,
                   WAKE_PIN_A | WAKE_PIN_B, RESET_PIN_WAKE, IO_WAKE};
        s2_reg <= s1_reg;
        pw1_reg <= PERIPH_WAKE;
        pw2_reg <= pw1_reg;
    end
    wire ser_start = s2_reg[SW-1];
    wire ser_addr = s2_reg[SW-2];
    wire ser_frame = s2_reg[SW-3];
    wire twi_match = s2_reg[SW-4];
    wire wake_pins = s2_reg[SW-5];
    wire rst_pin_wk = s2_reg[SW-6];
    wire any_io = |s2_reg[NIO-1:0];

    // ===========================================================
    // mode state machine
    typedef enum logic [1:0] {ST_ACTIVE, ST_ENTER, ST_LOW} lpmc_fsm_t;
    lpmc_fsm_t st_reg, st_next;
    lpmc_mode_t mode_reg, mode_next, target;
    logic [3:0] cnt_reg, cnt_next;

    wire in_stop = (mode_reg == LPMC_STOP0) || (mode_reg == LPMC_STOP1);
    wire [WK_N-1:0] wk_en = OPT_ENABLE | WK_N'(1 << LPMC_WK_RADIO) | WK_N'(1 << LPMC_WK_BROWNOUT)
                            | WK_N'(1 << LPMC_WK_WDOG);
    wire ser_irq = OPT_ENABLE[LPMC_WK_SERIAL] && (ser_start || ser_addr || ser_frame); // [R6]
    wire twi_irq = OPT_ENABLE[LPMC_WK_TWI] && twi_match;                              // [R7]
    logic [WK_N-1:0] pw_eff;
    always_comb begin
        pw_eff = pw2_reg & wk_en;                                                      // [R1]
        pw_eff[LPMC_WK_SERIAL] = ser_irq;
        pw_eff[LPMC_WK_TWI] = twi_irq;
    end
    wire stop_wake = rst_pin_wk || any_io || (|pw_eff);                                // [R9]
    wire stby_wake = rst_pin_wk || wake_pins || pw_eff[LPMC_WK_BROWNOUT]
                     || pw_eff[LPMC_WK_CAL] || pw_eff[LPMC_WK_WDOG];                  // [R12] [R15]
    wire shdn_wake = wake_pins || pw_eff[LPMC_WK_CAL];                                 // [R15]
    wire sleep_wake = rst_pin_wk || any_io || (|pw2_reg);
    wire deep_tgt = (target != LPMC_SLEEP) && (target != LPMC_LP_SLEEP);
    logic tgt_wake;

    always_comb begin
        if (!CPU_DEEP) begin
            target = LP_REGULATOR ? LPMC_LP_SLEEP : LPMC_SLEEP;
        end else begin
            unique case (MODE_SEL)                                                     // [R20]
                LPMC_SEL_STOP0: target = LPMC_STOP0;
                LPMC_SEL_STOP1: target = LPMC_STOP1;
                LPMC_SEL_STANDBY: target = LPMC_STANDBY;
                LPMC_SEL_SHUTDOWN: target = LPMC_SHUTDOWN;
                default: target = LPMC_STOP1;
            endcase
        end
        unique case (target)
            LPMC_STOP0, LPMC_STOP1: tgt_wake = stop_wake;
            LPMC_STANDBY: tgt_wake = stby_wake;
            LPMC_SHUTDOWN: tgt_wake = shdn_wake;
            default: tgt_wake = sleep_wake;
        endcase
    end

    logic low_wake;
    always_comb begin
        unique case (mode_reg)
            LPMC_STOP0, LPMC_STOP1: low_wake = stop_wake;
            LPMC_STANDBY: low_wake = stby_wake;
            LPMC_SHUTDOWN: low_wake = shdn_wake;
            default: low_wake = sleep_wake;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        mode_next = mode_reg;
        cnt_next = cnt_reg;
        unique case (st_reg)
            ST_ACTIVE: begin
                mode_next = lpmc_mode_t'(LP_REGULATOR ? LPMC_LP_RUN : LPMC_RUN);
                if (CPU_SLEEP_REQ) begin                                               // [R20]
                    st_next = ST_ENTER;
                    cnt_next = 4'(LPMC_ENTRY_CYCLES);
                end
            end
            ST_ENTER: begin
                if (tgt_wake || !deep_tgt && !CPU_SLEEP_REQ) begin                     // [R21]
                    st_next = ST_ACTIVE;
                end else if (cnt_reg == 4'h0) begin
                    st_next = ST_LOW;
                    mode_next = target;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            ST_LOW: begin
                if (low_wake) begin
                    st_next = ST_ACTIVE;
                    mode_next = lpmc_mode_t'(LP_REGULATOR ? LPMC_LP_RUN : LPMC_RUN);
                end
            end
            default: st_next = ST_ACTIVE;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            st_reg <= ST_ACTIVE;
            mode_reg <= LPMC_RUN;
            cnt_reg <= 4'h0;
        end else begin
            st_reg <= st_next;
            mode_reg <= mode_next;
            cnt_reg <= cnt_next;
        end
    end

    // ===========================================================
    // clock gating and availability decode
    wire lp_mode = (mode_next == LPMC_LP_RUN) || (mode_next == LPMC_LP_SLEEP);
    wire stop_n = (mode_next == LPMC_STOP0) || (mode_next == LPMC_STOP1);
    wire stby_n = (mode_next == LPMC_STANDBY);
    wire shdn_n = (mode_next == LPMC_SHUTDOWN);
    wire cpu_n = (mode_next == LPMC_RUN) || (mode_next == LPMC_LP_RUN);
    wire sram_on_n = !shdn_n;
    logic [WK_N-1:0] pclk_n;
    always_comb begin
        pclk_n = '1;
        pclk_n[LPMC_WK_VDET] = OPT_ENABLE[LPMC_WK_VDET] && !stby_n && !shdn_n;         // [R1]
        pclk_n[LPMC_WK_SERIAL] = OPT_ENABLE[LPMC_WK_SERIAL] && !stby_n && !shdn_n;     // [R8]
        pclk_n[LPMC_WK_TWI] = OPT_ENABLE[LPMC_WK_TWI] && !stby_n && !shdn_n;           // [R8]
        pclk_n[LPMC_WK_TIMER_A] = OPT_ENABLE[LPMC_WK_TIMER_A] && !stby_n && !shdn_n;   // [R11]
        pclk_n[LPMC_WK_TIMER_B] = OPT_ENABLE[LPMC_WK_TIMER_B] && !stby_n && !shdn_n;   // [R11]
        pclk_n[LPMC_WK_WDOG] = OPT_ENABLE[LPMC_WK_WDOG] && !shdn_n;                    // [R12]
        pclk_n[LPMC_WK_CAL] = OPT_ENABLE[LPMC_WK_CAL];
        pclk_n[LPMC_WK_RADIO] = !lp_mode && !stby_n && !shdn_n;                        // [R10]
        pclk_n[LPMC_WK_BROWNOUT] = !shdn_n;
    end

    // ===========================================================
    // io pull hold; shutdown setting is dropped on exit
    logic [2*NIO-1:0] pull_reg;
    logic analog_reg;
    logic leaving_shdn;
    logic cfg_lost_reg;
    assign leaving_shdn = (mode_reg == LPMC_SHUTDOWN) && (mode_next != LPMC_SHUTDOWN);

    logic [2:0] mode_o_reg;
    logic cpu_reg, other_reg, sa_reg, sb_reg, fpd_reg, pll_reg, rng_reg, hse_reg;
    logic ser_reg, twi_reg, wk_reg, rpu_reg;
    logic [WK_N-1:0] pclk_reg;
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            mode_o_reg <= 3'h0;
            cpu_reg <= 1'b1;
            other_reg <= 1'b1;
            pclk_reg <= '0;
            sa_reg <= LPMC_SRAM_GATE_RESET;
            sb_reg <= LPMC_SRAM_GATE_RESET;
            fpd_reg <= 1'b0;
            pll_reg <= 1'b0;
            rng_reg <= 1'b0;
            hse_reg <= 1'b0;
            ser_reg <= 1'b0;
            twi_reg <= 1'b0;
            wk_reg <= 1'b0;
            pull_reg <= '0;
            cfg_lost_reg <= 1'b0;
            analog_reg <= LPMC_ANALOG_RESET;                                           // [R18]
            rpu_reg <= 1'b0;
        end else begin
            mode_o_reg <= 3'(mode_next);
            cpu_reg <= cpu_n;
            other_reg <= !stop_n && !stby_n && !shdn_n;                                // [R8]
            pclk_reg <= pclk_n;
            sa_reg <= SRAM_A_EN && sram_on_n;                                          // [R2]
            sb_reg <= SRAM_B_EN && sram_on_n;                                          // [R2]
            fpd_reg <= (FLASH_PD_REQ && !RADIO_ACTIVE && CODE_IN_SRAM) || !sram_on_n;  // [R17]
            pll_reg <= !lp_mode && !stop_n && !stby_n && !shdn_n;                      // [R10]
            rng_reg <= OPT_ENABLE[LPMC_WK_RADIO] && !lp_mode && cpu_n;                 // [R10]
            hse_reg <= RADIO_ACTIVE && !lp_mode && !stby_n && !shdn_n;                 // [R16]
            ser_reg <= ser_irq && (in_stop || st_reg == ST_ENTER);                     // [R6]
            twi_reg <= twi_irq && (in_stop || st_reg == ST_ENTER);                     // [R7]
            wk_reg <= (st_reg == ST_LOW) && low_wake;
            // lost setting holds while software keeps its configuration asserted and clears when it drops
            cfg_lost_reg <= leaving_shdn || (cfg_lost_reg && IO_CONFIGURED);           // [R14]
            if (leaving_shdn || cfg_lost_reg) begin
                pull_reg <= '0;                                                        // [R14]
                analog_reg <= LPMC_ANALOG_RESET;
            end else if (stby_n || shdn_n) begin
                pull_reg <= IO_PULL_SEL;                                               // [R13]
            end else begin
                pull_reg <= IO_PULL_SEL;
                analog_reg <= analog_reg && !IO_CONFIGURED;
            end
            rpu_reg <= !INTERNAL_RESET;                                                // [R19]
        end
    end

    lpmc_osc_req #(.N(NREQ)) u_osc (
        .clk(CLOCK),
        .rst(RST),
        .stop_mode(in_stop),
        .req_async(OSC_REQ),
        .osc_on(FAST_INT_OSC_ON),
        .route(FAST_INT_OSC_ROUTE)
    );

    assign MODE = mode_o_reg;
    assign CPU_CLK_EN = cpu_reg;
    assign PERIPH_CLK_EN = pclk_reg;
    assign OTHER_PERIPH_CLK_EN = other_reg;
    assign SRAM_A_CLK_EN = sa_reg;
    assign SRAM_B_CLK_EN = sb_reg;
    assign FLASH_PD = fpd_reg;
    assign PLL_ALLOWED = pll_reg;
    assign RNG_EN = rng_reg;
    assign FAST_EXT_OSC_ON = hse_reg;
    assign SERIAL_WAKE_IRQ = ser_reg;
    assign TWI_WAKE_IRQ = twi_reg;
    assign WAKEUP = wk_reg;
    assign IO_PULL = pull_reg;
    assign IO_ANALOG = analog_reg;
    assign RESET_PULLUP_EN = rpu_reg;

    // ===========================================================
    // checks
    sequence s_entering;
        st_reg == ST_ENTER;
    endsequence
    chk_entry_on_req: assert property (@(posedge CLOCK) disable iff (RST)
        (st_reg == ST_ACTIVE && !CPU_SLEEP_REQ) |=> st_reg == ST_ACTIVE) else $error("entry without request"); // [R20]
    chk_entry_abort: assert property (@(posedge CLOCK) disable iff (RST)
        (s_entering and tgt_wake) |=> st_reg == ST_ACTIVE) else $error("wakeup lost during entry"); // [R21]
    chk_lp_no_pll: assert property (@(posedge CLOCK) disable iff (RST)
        (MODE == 3'(LPMC_LP_RUN)) |-> !PLL_ALLOWED && !RNG_EN) else $error("pll or rng in low-power run"); // [R10]
    chk_sram_a_gate: assert property (@(posedge CLOCK) disable iff (RST)
        !SRAM_A_EN |=> !SRAM_A_CLK_EN) else $error("sram a clock not gated"); // [R2]
    chk_radio_osc: assert property (@(posedge CLOCK) disable iff (RST)
        (RADIO_ACTIVE && stop_n) |=> FAST_EXT_OSC_ON) else $error("external osc off for radio"); // [R16]
    chk_shdn_pull_drop: assert property (@(posedge CLOCK) disable iff (RST)
        leaving_shdn |=> IO_PULL == '0 && IO_ANALOG) else $error("pull kept after shutdown"); // [R14]
    chk_reset_pullup: assert property (@(posedge CLOCK) disable iff (RST)
        INTERNAL_RESET |=> !RESET_PULLUP_EN) else $error("reset pull-up on with internal reset"); // [R19]
    chk_shdn_wdog_off: assert property (@(posedge CLOCK) disable iff (RST)
        shdn_n |=> !PERIPH_CLK_EN[LPMC_WK_WDOG] && !PERIPH_CLK_EN[LPMC_WK_TIMER_A]) else $error("clock in shutdown"); // [R12]
endmodule
`default_nettype wire

// File: lpmc_partner.sv
`timescale 1ns/100ps
`default_nettype none
module lpmc_partner
    import lpmc_pkg::*;
#(
    parameter int NREQ = 4
) (
    input wire logic clk,
    input wire logic stop_mode,
    input wire logic [NREQ-1:0] want,
    output logic [NREQ-1:0] osc_req
);
    // ===========================================================
    // wake-capable peripherals ask for the fast oscillator only while stopped
    always_ff @(posedge clk) begin
        osc_req <= stop_mode ? want : '0;
    end
endmodule
`default_nettype wire

// File: lpmc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module lpmc_top_tb
    import lpmc_pkg::*;
;
    logic CLOCK, RST, CPU_SLEEP_REQ, CPU_DEEP, LP_REGULATOR, SRAM_A_EN, SRAM_B_EN, FLASH_PD_REQ, CODE_IN_SRAM;
    logic RADIO_ACTIVE, SERIAL_START, SERIAL_ADDR_MATCH, SERIAL_FRAME, TWI_ADDR_MATCH, WAKE_PIN_A, WAKE_PIN_B;
    logic RESET_PIN_WAKE, INTERNAL_RESET, IO_CONFIGURED, stop_mode;
    logic [2:0] MODE_SEL, MODE;
    logic [LPMC_WK_COUNT-1:0] OPT_ENABLE, PERIPH_WAKE, PERIPH_CLK_EN;
    logic [3:0] OSC_REQ, want, FAST_INT_OSC_ROUTE, ev;
    logic [7:0] IO_WAKE;
    logic [15:0] IO_PULL_SEL, IO_PULL;
    logic [12:0] wk;
    logic CPU_CLK_EN, OTHER_PERIPH_CLK_EN, SRAM_A_CLK_EN, SRAM_B_CLK_EN, FLASH_PD, PLL_ALLOWED, RNG_EN;
    logic FAST_INT_OSC_ON, FAST_EXT_OSC_ON, SERIAL_WAKE_IRQ, TWI_WAKE_IRQ, WAKEUP, IO_ANALOG, RESET_PULLUP_EN;
    int failures, cmp_count;

    // ===========================================================
    // wake sources: 0..8 peripherals, 9 io, 10 reset pin, 11 pin a, 12 pin b
    assign PERIPH_WAKE = wk[8:0];
    assign IO_WAKE = {8{wk[9]}};
    assign RESET_PIN_WAKE = wk[10];
    assign WAKE_PIN_A = wk[11];
    assign WAKE_PIN_B = wk[12];
    // serial and two-wire sources wake through their event pins, not the wake vector
    assign {TWI_ADDR_MATCH, SERIAL_FRAME, SERIAL_ADDR_MATCH, SERIAL_START} = ev | {wk[6], wk[5], 2'h0};
    assign stop_mode = (MODE == LPMC_STOP0) || (MODE == LPMC_STOP1);

    lpmc_top #(.NIO(8), .NREQ(4)) lpmc_top_inst (.CLOCK, .RST, .CPU_SLEEP_REQ, .CPU_DEEP, .LP_REGULATOR,
        .MODE_SEL, .OPT_ENABLE, .SRAM_A_EN, .SRAM_B_EN, .FLASH_PD_REQ, .CODE_IN_SRAM, .RADIO_ACTIVE, .OSC_REQ,
        .SERIAL_START, .SERIAL_ADDR_MATCH, .SERIAL_FRAME, .TWI_ADDR_MATCH, .PERIPH_WAKE, .IO_WAKE, .WAKE_PIN_A,
        .WAKE_PIN_B, .RESET_PIN_WAKE, .INTERNAL_RESET, .IO_PULL_SEL, .IO_CONFIGURED, .MODE, .CPU_CLK_EN,
        .PERIPH_CLK_EN, .OTHER_PERIPH_CLK_EN, .SRAM_A_CLK_EN, .SRAM_B_CLK_EN, .FLASH_PD, .PLL_ALLOWED, .RNG_EN,
        .FAST_INT_OSC_ON, .FAST_INT_OSC_ROUTE, .FAST_EXT_OSC_ON, .SERIAL_WAKE_IRQ, .TWI_WAKE_IRQ, .WAKEUP,
        .IO_PULL, .IO_ANALOG, .RESET_PULLUP_EN);

    lpmc_partner #(.NREQ(4)) lpmc_partner_inst (.clk(CLOCK), .stop_mode(stop_mode), .want(want), .osc_req(OSC_REQ));

    initial begin
        CLOCK = 1'h0;
        forever #4 CLOCK = ~CLOCK;
    end

    // ===========================================================
    // shared helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_mode(input logic [2:0] m);
        repeat (40) if (MODE !== m) cyc(1);
    endtask

    task automatic enter(input logic deep, input logic [2:0] sel, input logic [2:0] m);
        CPU_DEEP = deep;
        MODE_SEL = sel;
        CPU_SLEEP_REQ = 1'h1;
        wait_mode(m);
        CPU_SLEEP_REQ = 1'h0;
        chk("entered mode", 16'(m), 16'(MODE));
    endtask

    // wake lands three edges after the source rises; WAKEUP stands for that cycle only
    task automatic try_wake(input int src, input logic [2:0] m);
        wk[src] = 1'h1;
        cyc(3);
        chk("wakeup pulse", 16'(m == LPMC_RUN), 16'(WAKEUP));
        cyc(5);
        chk("mode after wake", 16'(m), 16'(MODE));
        wk = '0;
        cyc(4);
    endtask

    task automatic test_done();
        $display("failures=%0d comparisons=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ===========================================================
    // scenarios
    task automatic t_reset();
        chk("reset mode", 16'(LPMC_RUN), 16'(MODE));
        chk("reset gates", 16'hF, 16'({CPU_CLK_EN, OTHER_PERIPH_CLK_EN, SRAM_A_CLK_EN, SRAM_B_CLK_EN}));
        chk("reset analog", 16'h1, 16'(IO_ANALOG));
        chk("reset pulls", 16'h0, IO_PULL);
        INTERNAL_RESET = 1'h1;
        cyc(3);
        chk("pullup internal", 16'h0, 16'(RESET_PULLUP_EN));
        INTERNAL_RESET = 1'h0;
        IO_CONFIGURED = 1'h1;
        cyc(3);
        chk("pullup external", 16'h1, 16'(RESET_PULLUP_EN));
        chk("analog cleared", 16'h0, 16'(IO_ANALOG));
    endtask

    task automatic t_run();
        chk("opt off", 16'h3, 16'(PERIPH_CLK_EN));
        OPT_ENABLE = 9'h1FF;
        SRAM_A_EN = 1'h0;
        cyc(3);
        chk("opt on", 16'h1FF, 16'(PERIPH_CLK_EN));
        chk("rng pll run", 16'h3, 16'({PLL_ALLOWED, RNG_EN}));
        chk("sram a off", 16'h1, 16'({SRAM_A_CLK_EN, SRAM_B_CLK_EN}));
        SRAM_A_EN = 1'h1;
        SRAM_B_EN = 1'h0;
        cyc(3);
        chk("sram b off", 16'h2, 16'({SRAM_A_CLK_EN, SRAM_B_CLK_EN}));
        SRAM_B_EN = 1'h1;
        FLASH_PD_REQ = 1'h1;
        CODE_IN_SRAM = 1'h1;
        RADIO_ACTIVE = 1'h1;
        cyc(3);
        chk("flash kept", 16'h0, 16'(FLASH_PD));
        chk("ext osc", 16'h1, 16'(FAST_EXT_OSC_ON));
        RADIO_ACTIVE = 1'h0;
        cyc(3);
        chk("flash down", 16'h1, 16'(FLASH_PD));
        FLASH_PD_REQ = 1'h0;
        LP_REGULATOR = 1'h1;
        cyc(3);
        chk("lp run pll rng", 16'h0, 16'({PLL_ALLOWED, RNG_EN}));
        enter(1'h0, LPMC_SEL_STOP0, LPMC_LP_SLEEP);
        chk("lp sleep pll rng", 16'h0, 16'({PLL_ALLOWED, RNG_EN}));
        LP_REGULATOR = 1'h0;
        try_wake(9, LPMC_RUN);
    endtask

    task automatic t_sleep();
        MODE_SEL = LPMC_SEL_STOP0;
        CPU_DEEP = 1'h1;
        cyc(20);
        chk("no request", 16'(LPMC_RUN), 16'(MODE));
        enter(1'h0, LPMC_SEL_STOP0, LPMC_SLEEP);
        chk("sleep cpu clk", 16'h0, 16'(CPU_CLK_EN));
        try_wake(9, LPMC_RUN);
    endtask

    // select code 2 is not a stop code and must fall back to stop level one
    task automatic t_stop_wake();
        logic [2:0] sel;
        for (int s = 0; s < 11; s++) begin
            sel = 3'(s % 3);
            enter(1'h1, sel, (sel == 3'h0) ? LPMC_STOP0 : LPMC_STOP1);
            chk("stop cpu frozen", 16'h0, 16'({CPU_CLK_EN, OTHER_PERIPH_CLK_EN}));
            chk("stop periph", 16'h1FF, 16'(PERIPH_CLK_EN));
            try_wake(s, LPMC_RUN);
        end
    endtask

    task automatic t_osc();
        enter(1'h1, LPMC_SEL_STOP0, LPMC_STOP0);
        want = 4'h2;
        cyc(6);
        chk("osc on", 16'h1, 16'(FAST_INT_OSC_ON));
        chk("osc route", 16'h2, 16'(FAST_INT_OSC_ROUTE));
        want = 4'hA;
        RADIO_ACTIVE = 1'h1;
        cyc(6);
        chk("osc route two", 16'hA, 16'(FAST_INT_OSC_ROUTE));
        chk("ext osc stop", 16'h1, 16'(FAST_EXT_OSC_ON));
        want = 4'h0;
        RADIO_ACTIVE = 1'h0;
        cyc(6);
        chk("osc off", 16'h0, 16'({FAST_INT_OSC_ON, FAST_INT_OSC_ROUTE}));
        try_wake(10, LPMC_RUN);
    endtask

    task automatic t_irq();
        for (int e = 0; e < 4; e++) begin
            enter(1'h1, LPMC_SEL_STOP1, LPMC_STOP1);
            ev = 4'(1 << e);
            cyc(3);
            chk("serial irq", 16'(e < 3), 16'(SERIAL_WAKE_IRQ));
            chk("twi irq", 16'(e == 3), 16'(TWI_WAKE_IRQ));
            ev = '0;
            wait_mode(LPMC_RUN);
            chk("irq wake", 16'(LPMC_RUN), 16'(MODE));
        end
    endtask

    task automatic t_deep();
        IO_PULL_SEL = 16'h1892;
        enter(1'h1, LPMC_SEL_STANDBY, LPMC_STANDBY);
        chk("standby pulls", 16'h1892, IO_PULL);
        chk("standby wdog", 16'h1, 16'(PERIPH_CLK_EN[LPMC_WK_WDOG]));
        chk("standby timers", 16'h0, 16'(PERIPH_CLK_EN[8:7]));
        try_wake(9, LPMC_STANDBY);
        try_wake(11, LPMC_RUN);
        enter(1'h1, LPMC_SEL_SHUTDOWN, LPMC_SHUTDOWN);
        chk("shutdown wdog", 16'h0, 16'(PERIPH_CLK_EN[LPMC_WK_WDOG]));
        try_wake(LPMC_WK_WDOG, LPMC_SHUTDOWN);
        try_wake(12, LPMC_RUN);
        chk("pulls dropped", 16'h0, IO_PULL);
        chk("analog again", 16'h1, 16'(IO_ANALOG));
    endtask

    // a design that ignores the wake enters stop after the wake is gone
    task automatic t_abort();
        MODE_SEL = LPMC_SEL_STOP1;
        CPU_DEEP = 1'h1;
        CPU_SLEEP_REQ = 1'h1;
        cyc(2);
        wk[9] = 1'h1;
        cyc(2);
        CPU_SLEEP_REQ = 1'h0;
        cyc(2);
        wk = '0;
        cyc(20);
        chk("abort mode", 16'(LPMC_RUN), 16'(MODE));
    endtask

    // ===========================================================
    // main sequence and watchdog
    initial begin
        failures = 0;
        cmp_count = 0;
        {RST, CPU_SLEEP_REQ, CPU_DEEP, LP_REGULATOR, FLASH_PD_REQ, CODE_IN_SRAM, RADIO_ACTIVE} = 7'h40;
        {SRAM_A_EN, SRAM_B_EN, INTERNAL_RESET, IO_CONFIGURED} = 4'hC;
        MODE_SEL = 3'h0;
        OPT_ENABLE = '0;
        IO_PULL_SEL = '0;
        want = '0;
        wk = '0;
        ev = '0;
        cyc(16);
        RST = 1'h0;
        cyc(3);
        t_reset();
        t_run();
        t_sleep();
        t_stop_wake();
        t_osc();
        t_irq();
        t_deep();
        t_abort();
        test_done();
    end

    // the whole sequence needs about four microseconds
    initial begin
        #200000;
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
